// ===== logic/sat_pkg.sv
// constants and types for the segment address translation block
// assumes one core clock; used by the translation top only, as the segment base store uses its own literals
package sat_pkg;
    // ************************************************************
    // widths and fixed figures
    // ************************************************************
    localparam int ADDR_W = 32;
    localparam int SEL_W = 16;
    localparam int PORT_W = 16;
    localparam int IMM_PORT_W = 8;
    localparam int REAL_SHIFT = 4;
    localparam int PAGE_OFS_W = 12;
    localparam int PAGE_NUM_W = ADDR_W - PAGE_OFS_W;
    localparam logic [15:0] RSVD_PORT_LO = 16'h00F8;
    localparam logic [15:0] RSVD_PORT_HI = 16'h00FF;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

    // segment register numbering
    typedef enum logic [2:0] {
        SAT_SEG_EXTRA = 3'h0,
        SAT_SEG_CODE = 3'h1,
        SAT_SEG_STACK = 3'h2,
        SAT_SEG_DATA = 3'h3,
        SAT_SEG_AUX_F = 3'h4,
        SAT_SEG_AUX_G = 3'h5
    } sat_seg_t;

    // kind of reference issued by the execution unit
    typedef enum logic [2:0] {
        SAT_REF_FETCH = 3'h0,
        SAT_REF_PUSH = 3'h1,
        SAT_REF_POP = 3'h2,
        SAT_REF_STR_DEST = 3'h3,
        SAT_REF_DATA = 3'h4,
        SAT_REF_IO = 3'h5
    } sat_ref_t;

    // operand size
    typedef enum logic [1:0] {
        SAT_SZ_BYTE = 2'h0,
        SAT_SZ_HALF = 2'h1,
        SAT_SZ_WORD = 2'h2
    } sat_size_t;

    // general register numbers that matter for segment choice
    localparam logic [2:0] GPR_STACK_PTR = 3'h4;
    localparam logic [2:0] GPR_FRAME_BASE = 3'h5;
endpackage

// ===== logic/sat_seg_base_mem.sv
// segment selector and base store, six entries, registered read
// assumes the execution unit writes bases after descriptor loads
`timescale 1ns/1ps
module sat_seg_base_mem (
    input wire logic core_clk, // core clock
    input wire logic arst_n, // async reset, active low
    input wire logic wr_en, // write strobe
    input wire logic [2:0] wr_idx, // segment written
    input wire logic [15:0] wr_sel, // selector value
    input wire logic [31:0] wr_base, // descriptor linear base
    input wire logic [2:0] rd_idx, // segment read
    output logic [15:0] rd_sel, // registered selector
    output logic [31:0] rd_base // registered base
);
    logic [15:0] sel_mem [6];
    logic [31:0] base_mem [6];

    // ************************************************************
    // storage
    // ************************************************************
    // bases carry no restriction so every segment may share one value
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 6; i++) begin
                sel_mem[i] <= 16'h0000;
                base_mem[i] <= 32'h0000_0000;
            end
            rd_sel <= 16'h0000;
            rd_base <= 32'h0000_0000;
        end else begin
            if (wr_en && wr_idx < 3'h6) begin
                sel_mem[wr_idx] <= wr_sel;
                base_mem[wr_idx] <= wr_base;
            end
            rd_sel <= (rd_idx < 3'h6) ? sel_mem[rd_idx] : 16'h0000;
            rd_base <= (rd_idx < 3'h6) ? base_mem[rd_idx] : 32'h0000_0000;
        end
    end
endmodule

// ===== logic/sat_top.sv
// segment address translation: effective address, segment choice, linear
// and physical address, I/O port address and memory/IO select
// assumes a request pulse from the execution unit and a paging unit that
// answers a page lookup in the stage-1 cycle, one cycle ahead of its pg_req pulse
`timescale 1ns/1ps
module sat_top (
    input wire logic core_clk, // core clock, 250 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic seg_wr_en, // segment load strobe
    input wire logic [2:0] seg_wr_idx, // segment loaded
    input wire logic [15:0] seg_wr_sel, // selector loaded
    input wire logic [31:0] seg_wr_base, // descriptor base loaded
    input wire logic prot_mode, // 1 protected, 0 real
    input wire logic paging_en, // paging enable
    input wire logic req_valid, // request pulse
    input wire logic [2:0] req_kind, // sat_ref_t
    input wire logic [1:0] req_size, // sat_size_t
    input wire logic ovr_valid, // override prefix present
    input wire logic [2:0] ovr_seg, // overriding segment
    input wire logic [2:0] base_gpr, // number of base register
    input wire logic base_used, // base component present
    input wire logic [31:0] base_val, // base register value
    input wire logic index_used, // index component present
    input wire logic [31:0] index_val, // index register value
    input wire logic [1:0] scale_log2, // scale 1,2,4,8
    input wire logic [31:0] disp_val, // displacement
    input wire logic [31:0] instr_ptr, // instruction pointer
    input wire logic port_from_imm, // port from immediate field
    input wire logic [7:0] port_imm, // immediate port number
    input wire logic [15:0] port_addr_gpr, // port address register
    output logic pg_req, // lookup pulse to paging unit
    output logic [19:0] pg_lin_page, // linear page number
    input wire logic [19:0] pg_phys_page, // physical page answer
    output logic out_valid, // address valid pulse
    output logic [31:0] phys_addr, // physical address
    output logic [31:0] lin_addr, // linear address
    output logic [3:0] byte_en, // bytes of the operand
    output logic mem_io_sel, // 1 memory, 0 I/O
    output logic [2:0] seg_used // segment chosen
);
    // ************************************************************
    // effective address
    // ************************************************************
    // scaled index: only shifts, so no multiplier is needed
    function automatic logic [31:0] scale_idx(input logic [31:0] v, input logic [1:0] s);
        return v << s;
    endfunction

    wire [31:0] ea_base = base_used ? base_val : 32'h0000_0000;
    wire [31:0] ea_index = index_used ? scale_idx(index_val, scale_log2) : 32'h0000_0000;
    wire [31:0] eff_addr = ea_base + ea_index + disp_val;

    // ************************************************************
    // segment choice
    // ************************************************************
    // fixed-segment kinds ignore any prefix; overrides apply only to plain data and I/O kinds
    wire is_fetch = req_kind == sat_pkg::SAT_REF_FETCH;
    wire is_stack = req_kind == sat_pkg::SAT_REF_PUSH || req_kind == sat_pkg::SAT_REF_POP;
    wire is_str = req_kind == sat_pkg::SAT_REF_STR_DEST;
    wire is_io = req_kind == sat_pkg::SAT_REF_IO;
    wire stack_base = base_used &&
        (base_gpr == sat_pkg::GPR_STACK_PTR || base_gpr == sat_pkg::GPR_FRAME_BASE);
    wire [2:0] data_dflt = stack_base ? 3'(sat_pkg::SAT_SEG_STACK) : 3'(sat_pkg::SAT_SEG_DATA);
    wire ovr_ok = ovr_valid && ovr_seg < 3'h6;
    wire [2:0] data_seg = ovr_ok ? ovr_seg : data_dflt;
    wire [2:0] seg_sel =
        is_fetch ? 3'(sat_pkg::SAT_SEG_CODE) :
        is_stack ? 3'(sat_pkg::SAT_SEG_STACK) :
        is_str ? 3'(sat_pkg::SAT_SEG_EXTRA) :
        data_seg;
    // fetch uses the instruction pointer as offset
    wire [31:0] offset = is_fetch ? instr_ptr : eff_addr;

    // ************************************************************
    // stage 1: capture request while the segment store reads
    // ************************************************************
    logic s1_v_q;
    logic s1_io_q;
    logic [31:0] s1_ofs_q;
    logic [15:0] s1_port_q;
    logic [1:0] s1_size_q;
    logic [2:0] s1_seg_q;
    logic s1_prot_q;
    logic s1_pg_q;
    logic [15:0] seg_sel_rd;
    logic [31:0] seg_base_rd;

    sat_seg_base_mem u_mem (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wr_en(seg_wr_en),
        .wr_idx(seg_wr_idx),
        .wr_sel(seg_wr_sel),
        .wr_base(seg_wr_base),
        .rd_idx(seg_sel),
        .rd_sel(seg_sel_rd),
        .rd_base(seg_base_rd)
    );

    // port number from immediate or register, widened with zeros
    wire [15:0] port_num = port_from_imm ? {8'h00, port_imm} : port_addr_gpr;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_v_q <= 1'b0;
            s1_io_q <= 1'b0;
            s1_ofs_q <= 32'h0000_0000;
            s1_port_q <= 16'h0000;
            s1_size_q <= 2'h0;
            s1_seg_q <= 3'h0;
            s1_prot_q <= 1'b0;
            s1_pg_q <= 1'b0;
        end else begin
            s1_v_q <= req_valid;
            if (req_valid) begin
                s1_io_q <= is_io;
                s1_ofs_q <= offset;
                s1_port_q <= port_num;
                s1_size_q <= req_size;
                s1_seg_q <= seg_sel;
                s1_prot_q <= prot_mode;
                s1_pg_q <= paging_en;
            end
        end
    end

    // ************************************************************
    // linear address
    // ************************************************************
    // real mode: selector times sixteen plus offset, carried at full width
    wire [32:0] real_sum = {13'h0000, seg_sel_rd, 4'h0} + {1'b0, s1_ofs_q};
    // protected mode: descriptor base plus offset; wraps like the address bus
    wire [31:0] prot_lin = seg_base_rd + s1_ofs_q;
    // the linear bus is 32 bits, so the real mode carry falls off only here
    wire [31:0] lin_d = s1_prot_q ? prot_lin : real_sum[31:0];
    wire [31:0] io_addr = {16'h0000, s1_port_q};

    // ************************************************************
    // byte lanes: low byte at the operand address, rising upward
    // ************************************************************
    function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] m;
        m = 4'h1;
        if (sz == 2'(sat_pkg::SAT_SZ_HALF)) begin
            m = 4'h3;
        end else if (sz == 2'(sat_pkg::SAT_SZ_WORD)) begin
            m = 4'hF;
        end
        return 4'(m << a);
    endfunction

    wire [1:0] lo_bits = s1_io_q ? s1_port_q[1:0] : lin_d[1:0];
    wire [3:0] be_d = lanes(s1_size_q, lo_bits);
    // pages are 4 Kbyte: the low 12 bits pass untouched through paging
    wire use_pg = !s1_io_q && s1_pg_q;
    wire [31:0] phys_d =
        s1_io_q ? io_addr :
        use_pg ? {pg_phys_page, lin_d[sat_pkg::PAGE_OFS_W-1:0]} :
        lin_d;

    // ************************************************************
    // output registers
    // ************************************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid <= 1'b0;
            phys_addr <= sat_pkg::ADDR_RST;
            lin_addr <= sat_pkg::ADDR_RST;
            byte_en <= 4'h0;
            mem_io_sel <= 1'b1;
            seg_used <= 3'h0;
            pg_req <= 1'b0;
            pg_lin_page <= 20'h00000;
        end else begin
            out_valid <= s1_v_q;
            pg_req <= s1_v_q && use_pg;
            if (s1_v_q) begin
                phys_addr <= phys_d;
                lin_addr <= s1_io_q ? io_addr : lin_d;
                byte_en <= be_d;
                mem_io_sel <= !s1_io_q;
                seg_used <= s1_seg_q;
                pg_lin_page <= lin_d[31:sat_pkg::PAGE_OFS_W];
            end
        end
    end
endmodule

// ===== tb/sat_pg_model.sv
// paging unit stand-in: maps a linear page to a physical page
// assumes the bench presents the page of the request in flight
`timescale 1ns/1ps
module sat_pg_model #(parameter logic [19:0] MAP = 20'h5A5A5) (
    input wire logic lk_en, // lookup in flight
    input wire logic [19:0] lk_page, // linear page asked
    output logic [19:0] phys_page // physical page answer
);
    // outside a lookup the answer is inverted, so a stale sample never matches
    assign phys_page = lk_en ? (lk_page ^ MAP) : ~(lk_page ^ MAP);
endmodule

// ===== tb/sat_top_props.sv
// port-level checks of the translation top
// assumes the fixed two-cycle answer of the request pipeline
`timescale 1ns/1ps
module sat_top_props (
    input wire logic core_clk, // core clock
    input wire logic arst_n, // async reset, active low
    input wire logic paging_en, // paging enable
    input wire logic req_valid, // request pulse
    input wire logic [2:0] req_kind, // reference kind
    input wire logic ovr_valid, // override present
    input wire logic [2:0] ovr_seg, // override segment
    input wire logic pg_req, // lookup pulse
    input wire logic [19:0] pg_lin_page, // linear page
    input wire logic out_valid, // result pulse
    input wire logic [31:0] phys_addr, // physical address
    input wire logic [31:0] lin_addr, // linear address
    input wire logic mem_io_sel, // 1 memory, 0 I/O
    input wire logic [2:0] seg_used // chosen segment
);
    // ****************************************
    // request decode and properties
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // named kinds keep the properties short
    wire logic is_io = req_kind == 3'h5;
    wire logic is_stk = req_kind == 3'h1 || req_kind == 3'h2;
    a_io_select_low: assert property (req_valid && is_io |-> ##2 out_valid && !mem_io_sel)
        else $error("io request did not drive select low");
    a_mem_select_high: assert property (req_valid && !is_io |-> ##2 out_valid && mem_io_sel)
        else $error("memory request did not drive select high");
    a_io_port_zext: assert property (out_valid && !mem_io_sel |-> lin_addr[31:16] == 16'h0000 && phys_addr == lin_addr && !pg_req)
        else $error("io address not a bare zero-extended port");
    a_fetch_code_seg: assert property (req_valid && req_kind == 3'h0 |-> ##2 seg_used == 3'h1)
        else $error("fetch not on code segment");
    a_stack_ref_seg: assert property (req_valid && is_stk |-> ##2 seg_used == 3'h2)
        else $error("stack reference not on stack segment");
    a_string_dest_seg: assert property (req_valid && req_kind == 3'h3 |-> ##2 seg_used == 3'h0)
        else $error("string destination not on extra segment");
    a_override_data: assert property (req_valid && req_kind == 3'h4 && ovr_valid && ovr_seg < 3'h6
        |-> ##2 seg_used == $past(ovr_seg, 2))
        else $error("override segment not used");
    a_nopage_pass: assert property (req_valid && !paging_en && !is_io |-> ##2 phys_addr == lin_addr && !pg_req)
        else $error("linear address altered with paging off");
    a_page_lookup: assert property (req_valid && paging_en && !is_io
        |-> ##2 pg_req && pg_lin_page == lin_addr[31:12] && phys_addr[11:0] == lin_addr[11:0])
        else $error("paging lookup or page offset wrong");
endmodule
bind sat_top sat_top_props props (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .paging_en(paging_en),
    .req_valid(req_valid),
    .req_kind(req_kind),
    .ovr_valid(ovr_valid),
    .ovr_seg(ovr_seg),
    .pg_req(pg_req),
    .pg_lin_page(pg_lin_page),
    .out_valid(out_valid),
    .phys_addr(phys_addr),
    .lin_addr(lin_addr),
    .mem_io_sel(mem_io_sel),
    .seg_used(seg_used)
);

// ===== tb/sat_top_test.sv
// self-checking bench for the translation top with a paging stand-in
// assumes the two-cycle answer and a same-cycle page lookup
`timescale 1ns/1ps
module sat_top_test;
    localparam logic [19:0] MAP = 20'h5A5A5;
    logic core_clk = 1'b0, arst_n = 1'b0, seg_wr_en = 1'b0, prot_mode = 1'b0, paging_en = 1'b0;
    logic req_valid = 1'b0, ovr_valid = 1'b0, base_used = 1'b0, index_used = 1'b0, port_from_imm = 1'b0;
    logic lk_en = 1'b0, pg_req, out_valid, mem_io_sel;
    logic [2:0] seg_wr_idx = 3'h0, req_kind = 3'h0, ovr_seg = 3'h0, base_gpr = 3'h0, seg_used;
    logic [1:0] req_size = 2'h0, scale_log2 = 2'h0;
    logic [15:0] seg_wr_sel = 16'h0000, port_addr_gpr = 16'h0000;
    logic [31:0] seg_wr_base = 32'h0, base_val = 32'h0, index_val = 32'h0, disp_val = 32'h0, instr_ptr = 32'h0;
    logic [31:0] phys_addr, lin_addr, exp_lin;
    logic [7:0] port_imm = 8'h00;
    logic [19:0] lk_page = 20'h00000, pg_phys_page, pg_lin_page;
    logic [3:0] byte_en;
    logic [31:0] seg_base [0:5];
    int failures = 0, n_compared = 0, cyc = 0;
    sat_top dut (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .seg_wr_en(seg_wr_en),
        .seg_wr_idx(seg_wr_idx),
        .seg_wr_sel(seg_wr_sel),
        .seg_wr_base(seg_wr_base),
        .prot_mode(prot_mode),
        .paging_en(paging_en),
        .req_valid(req_valid),
        .req_kind(req_kind),
        .req_size(req_size),
        .ovr_valid(ovr_valid),
        .ovr_seg(ovr_seg),
        .base_gpr(base_gpr),
        .base_used(base_used),
        .base_val(base_val),
        .index_used(index_used),
        .index_val(index_val),
        .scale_log2(scale_log2),
        .disp_val(disp_val),
        .instr_ptr(instr_ptr),
        .port_from_imm(port_from_imm),
        .port_imm(port_imm),
        .port_addr_gpr(port_addr_gpr),
        .pg_req(pg_req),
        .pg_lin_page(pg_lin_page),
        .pg_phys_page(pg_phys_page),
        .out_valid(out_valid),
        .phys_addr(phys_addr),
        .lin_addr(lin_addr),
        .byte_en(byte_en),
        .mem_io_sel(mem_io_sel),
        .seg_used(seg_used)
    );
    sat_pg_model #(.MAP(MAP)) pager (.lk_en(lk_en), .lk_page(lk_page), .phys_page(pg_phys_page));
    // ****************************************
    // clock, watchdog, verdict
    // ****************************************
    initial forever #2 core_clk = ~core_clk;
    // a hang counts as a mismatch and closes the run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 1000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
        chk32({28'h0, got}, {28'h0, exp});
    endtask
    // ****************************************
    // bus-side helpers, all entered at a falling edge
    // ****************************************
    task automatic seg_load(input logic [2:0] idx, input logic [15:0] sel, input logic [31:0] base);
        seg_wr_idx = idx;
        seg_wr_sel = sel;
        seg_wr_base = base;
        seg_wr_en = 1'b1;
        seg_base[idx] = base;
        @(negedge core_clk);
        seg_wr_en = 1'b0;
        // one idle edge, so a following load never re-raises the strobe in this time step
        @(negedge core_clk);
    endtask
    // one request; the pager is told the expected page since the lookup precedes pg_lin_page
    task automatic issue(input logic [2:0] kind, input logic [2:0] seg, input logic [31:0] phys);
        req_kind = kind;
        req_valid = 1'b1;
        lk_page = exp_lin[31:12];
        @(negedge core_clk);
        // the page answer is needed only in the stage-1 cycle
        req_valid = 1'b0;
        lk_en = paging_en;
        @(negedge core_clk);
        // out_valid stands for this one cycle only
        lk_en = 1'b0;
        chk4({3'h0, out_valid}, 4'h1);
        if (kind != 3'h5) chk4({1'b0, seg_used}, {1'b0, seg});
        chk32(lin_addr, exp_lin);
        chk32(phys_addr, phys);
        chk4({3'h0, mem_io_sel}, {3'h0, kind != 3'h5});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_real_fetch;
        seg_load(3'h1, 16'hFFFF, 32'h0);
        instr_ptr = 32'h0000_FFFF;
        ovr_valid = 1'b1;
        ovr_seg = 3'h3;
        exp_lin = 32'h0010_FFEF;
        issue(3'h0, 3'h1, exp_lin);
    endtask
    task automatic t_prot_data;
        logic [2:0] s;
        prot_mode = 1'b1;
        seg_load(3'h2, 16'h0010, 32'h2000_0000);
        seg_load(3'h3, 16'h0018, 32'h1000_0000);
        seg_load(3'h4, 16'h0020, 32'h3000_0000);
        base_used = 1'b1;
        index_used = 1'b1;
        base_val = 32'h100;
        index_val = 32'h10;
        disp_val = 32'h3;
        req_size = 2'h2;
        ovr_seg = 3'h4;
        for (int g = 0; g < 8; g++) begin
            base_gpr = g[2:0];
            scale_log2 = g[1:0];
            ovr_valid = g == 7;
            s = (g == 7) ? 3'h4 : (g == 4 || g == 5) ? 3'h2 : 3'h3;
            exp_lin = seg_base[s] + 32'h103 + (32'h10 << g[1:0]);
            issue(3'h4, s, exp_lin);
            chk4(byte_en, 4'h8);
        end
    endtask
    task automatic t_stack_string;
        logic [2:0] s;
        base_used = 1'b0;
        index_used = 1'b0;
        disp_val = 32'h0000_2001;
        req_size = 2'h1;
        ovr_valid = 1'b1;
        ovr_seg = 3'h5;
        seg_load(3'h0, 16'h0008, 32'h4000_0000);
        for (int k = 1; k < 4; k++) begin
            s = (k == 3) ? 3'h0 : 3'h2;
            exp_lin = seg_base[s] + 32'h2001;
            issue(k[2:0], s, exp_lin);
            chk4(byte_en, 4'h6);
        end
    endtask
    task automatic t_page_io;
        paging_en = 1'b1;
        ovr_valid = 1'b0;
        req_size = 2'h0;
        base_gpr = 3'h0;
        disp_val = 32'h0012_3456;
        exp_lin = seg_base[3] + 32'h0012_3456;
        issue(3'h4, 3'h3, {exp_lin[31:12] ^ MAP, exp_lin[11:0]});
        chk4(byte_en, 4'h4);
        // port kept clear of the held-back range
        port_from_imm = 1'b1;
        port_imm = 8'h71;
        exp_lin = 32'h0000_0071;
        issue(3'h5, 3'h0, exp_lin);
        port_from_imm = 1'b0;
        port_addr_gpr = 16'hBEEF;
        exp_lin = 32'h0000_BEEF;
        issue(3'h5, 3'h0, exp_lin);
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        t_real_fetch();
        t_prot_data();
        t_stack_string();
        t_page_io();
        print_verdict();
    end
endmodule
